// File: rtl/cmab_pkg.sv
// Constants, register map and shared decoding for the receive mask block.
package cmab_pkg;

	// Structure sizes.
	localparam int NUM_FLT  = 8;
	localparam int NUM_MASK = 3;
	localparam int NUM_BUF  = 32;
	localparam int SID_W    = 11;
	localparam int EID_W    = 18;
	localparam int REG_W    = 16;
	localparam int IDX_W    = 5;
	localparam int IRQ_W    = 2;

	// Register byte addresses on the APB port.
	localparam logic [7:0] ADDR_MSKSEL   = 8'h00;
	localparam logic [7:0] ADDR_MSTD0    = 8'h04;
	localparam logic [7:0] ADDR_MEXT0    = 8'h10;
	localparam logic [7:0] ADDR_FULL_LO  = 8'h1C;
	localparam logic [7:0] ADDR_FULL_HI  = 8'h20;
	localparam logic [7:0] ADDR_OVF_LO   = 8'h24;
	localparam logic [7:0] ADDR_OVF_HI   = 8'h28;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h2C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h30;
	localparam logic [7:0] ADDR_STRIDE   = 8'h04;

	// Field positions inside the mask standard identifier register.
	localparam int MSTD_SID_LSB  = 5;
	localparam int MSTD_ID_TYPE_MATCH_MODE_BIT = 3;
	localparam int MSTD_EIDH_W   = 2;

	// Mask source codes; the top code names no mask.
	localparam logic [1:0] MSK_SRC_RSVD = 2'h3;

	// Interrupt status bit positions.
	localparam int IRQ_RX_BIT  = 0;
	localparam int IRQ_OVF_BIT = 1;

	// Values after reset.
	localparam logic [15:0] RST_MSKSEL = 16'h0000;
	localparam logic [31:0] RST_FLAGS  = 32'h0000_0000;
	localparam logic [SID_W-1:0] RST_MSTD = 11'h000;
	localparam logic [EID_W-1:0] RST_MEXT = 18'h00000;
	localparam logic [1:0]  RST_IRQ    = 2'h0;

	// Maps a mask source code onto a legal mask index.
	function automatic logic [1:0] mask_index(input logic [1:0] code);
		return (code == MSK_SRC_RSVD) ? 2'h0 : code;
	endfunction

endpackage

// File: rtl/cmab_flt_if.sv
// Bundle between the register core and the acceptance match logic.
`timescale 1ns/1ps
interface cmab_flt_if;
	logic [15:0]                                       mask_sel;
	logic [cmab_pkg::NUM_MASK-1:0][cmab_pkg::SID_W-1:0] mask_std;
	logic [cmab_pkg::NUM_MASK-1:0][cmab_pkg::EID_W-1:0] mask_ext;
	logic [cmab_pkg::NUM_MASK-1:0]                     mask_id_type_match_mode;
	logic [cmab_pkg::NUM_FLT-1:0][cmab_pkg::SID_W-1:0]  filt_std;
	logic [cmab_pkg::NUM_FLT-1:0][cmab_pkg::EID_W-1:0]  filt_ext;
	logic [cmab_pkg::NUM_FLT-1:0]                      filt_xen;
	logic [cmab_pkg::SID_W-1:0]                        rx_std;
	logic [cmab_pkg::EID_W-1:0]                        rx_ext;
	logic                                              rx_is_ext;
	logic [cmab_pkg::NUM_FLT-1:0]                      hit;

	modport core (output mask_sel, mask_std, mask_ext, mask_id_type_match_mode,
		filt_std, filt_ext, filt_xen, rx_std, rx_ext, rx_is_ext,
		input hit);
	modport match (input mask_sel, mask_std, mask_ext, mask_id_type_match_mode,
		filt_std, filt_ext, filt_xen, rx_std, rx_ext, rx_is_ext,
		output hit);
endinterface

// File: rtl/cmab_match.sv
// Combinational acceptance compare for filters 8 to 15.
`timescale 1ns/1ps
module cmab_match (
	// Configuration, received identifier and hit vector.
	cmab_flt_if.match fi
);

	// One comparator per filter; slot i serves filter 8 + i.
	genvar i;
	generate
		for (i = 0; i < cmab_pkg::NUM_FLT; i++) begin : g_flt
			logic [1:0]                 code;
			logic [1:0]                 midx;
			logic [cmab_pkg::SID_W-1:0] sid_bad;
			logic [cmab_pkg::EID_W-1:0] eid_bad;
			logic                       type_ok;

			// Two bits per filter, filter 8 in the lowest pair.
			assign code = fi.mask_sel[2*i +: 2];
			assign midx = cmab_pkg::mask_index(code);
			// A differing bit counts only where the mask includes it.
			assign sid_bad = (fi.rx_std ^ fi.filt_std[i])
				& fi.mask_std[midx];
			assign eid_bad = (fi.rx_ext ^ fi.filt_ext[i])
				& fi.mask_ext[midx];
			// Type gate is open unless the mask asks for type matching.
			assign type_ok = !fi.mask_id_type_match_mode[midx] ||
				(fi.rx_is_ext == fi.filt_xen[i]);
			// Standard frames compare the standard part only.
			assign fi.hit[i] = (code != cmab_pkg::MSK_SRC_RSVD) && type_ok
				&& (sid_bad == '0)
				&& (!fi.rx_is_ext || eid_bad == '0);
		end
	endgenerate

endmodule

// File: rtl/cmab_top.sv
// Receive mask selection, mask registers and buffer full/overflow flags.
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps

module cmab_top (
	// Clock and reset.
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// APB slave.
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [7:0]                paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Filter 8-15 settings from the filter register block.
	input  wire logic [7:0][10:0]          filt_std_id,
	input  wire logic [7:0][17:0]          filt_ext_id,
	input  wire logic [7:0]                filter_extended_enable,
	// Received identifier from the protocol engine.
	input  wire logic                      rx_valid,
	input  wire logic [10:0]               rx_std_id,
	input  wire logic [17:0]               rx_ext_id,
	input  wire logic                      rx_is_ext,
	// Buffer write notice from the protocol engine.
	input  wire logic                      buf_wr,
	input  wire logic [4:0]                buf_idx,
	// Results.
	output logic      [7:0]                filter_hit,
	output logic                           filter_hit_valid,
	output logic      [31:0]               rx_buffer_full_flag,
	output logic      [31:0]               rx_buffer_overflow_flag,
	output logic                           irq
);

	cmab_flt_if fi ();

	logic [15:0]       msksel_r;
	logic [2:0][10:0]  mstd_r;
	logic [2:0][17:0]  mext_r;
	logic [2:0]        id_type_match_mode_r;
	logic [31:0]       full_r;
	logic [31:0]       ovf_r;
	logic [1:0]        irq_stat_r;
	logic [1:0]        irq_mask_r;
	logic [31:0]       prdata_r;
	logic              pready_r;
	logic              pslverr_r;
	logic              irq_r;
	logic [7:0]        hit_r;
	logic              hit_valid_r;
	logic              wr_en;
	logic [31:0]       rd_word;
	logic              rd_hit;
	logic [31:0]       full_clr;
	logic [31:0]       ovf_clr;
	logic [31:0]       full_set;
	logic [31:0]       ovf_set;
	logic [1:0]        irq_ev;

	// Clear mask for a flag pair split over a low and a high register.
	function automatic logic [31:0] w1c_mask(input logic lo, input logic hi,
		input logic [15:0] d);
		return {hi ? d : 16'h0000, lo ? d : 16'h0000};
	endfunction

	// Write strobe: the access edge at which pready is sampled high.
	assign wr_en = psel && penable && pready_r && pwrite;

	// Mask select register, all fields share one encoding.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msksel_r <= cmab_pkg::RST_MSKSEL;
		end else if (wr_en && paddr == cmab_pkg::ADDR_MSKSEL) begin
			msksel_r <= pwdata[15:0];
		end
	end

	// Mask registers; cleared at reset so outputs are never unknown.
	genvar m;
	generate
		for (m = 0; m < cmab_pkg::NUM_MASK; m++) begin : g_mask
			localparam logic [7:0] A_STD = cmab_pkg::ADDR_MSTD0
				+ 8'(m * 4);
			localparam logic [7:0] A_EXT = cmab_pkg::ADDR_MEXT0
				+ 8'(m * 4);
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mstd_r[m] <= cmab_pkg::RST_MSTD;
					mext_r[m] <= cmab_pkg::RST_MEXT;
					id_type_match_mode_r[m] <= 1'b0;
				end else if (wr_en && paddr == A_STD) begin
					// Bits 4 and 2 are dropped on write.
					mstd_r[m] <= pwdata[15:cmab_pkg::MSTD_SID_LSB];
					id_type_match_mode_r[m] <= pwdata[cmab_pkg::MSTD_ID_TYPE_MATCH_MODE_BIT];
					mext_r[m][17:16] <= pwdata[1:0];
				end else if (wr_en && paddr == A_EXT) begin
					mext_r[m][15:0] <= pwdata[15:0];
				end
			end
		end
	endgenerate

	// Clear requests and hardware set events for the flag registers.
	assign full_clr = w1c_mask(wr_en && paddr == cmab_pkg::ADDR_FULL_LO,
		wr_en && paddr == cmab_pkg::ADDR_FULL_HI, pwdata[15:0]);
	assign ovf_clr = w1c_mask(wr_en && paddr == cmab_pkg::ADDR_OVF_LO,
		wr_en && paddr == cmab_pkg::ADDR_OVF_HI, pwdata[15:0]);
	assign full_set = buf_wr ? (32'h0000_0001 << buf_idx) : 32'h0000_0000;
	assign ovf_set  = full_set & full_r;

	// Full flags; a set in the clearing cycle wins so no message is lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			full_r <= cmab_pkg::RST_FLAGS;
		end else begin
			full_r <= (full_r & ~full_clr) | full_set;
		end
	end

	// Overflow flags; hardware only ever sets them.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_r <= cmab_pkg::RST_FLAGS;
		end else begin
			ovf_r <= (ovf_r & ~ovf_clr) | ovf_set;
		end
	end

	// Interrupt status, write one to clear, set wins.
	assign irq_ev = {|ovf_set, buf_wr};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= cmab_pkg::RST_IRQ;
			irq_mask_r <= cmab_pkg::RST_IRQ;
		end else begin
			irq_stat_r <= (irq_stat_r & ~((wr_en &&
				paddr == cmab_pkg::ADDR_IRQ_STAT) ? pwdata[1:0] : 2'h0))
				| irq_ev;
			if (wr_en && paddr == cmab_pkg::ADDR_IRQ_MASK) begin
				irq_mask_r <= pwdata[1:0];
			end
		end
	end

	// Level interrupt, one cycle behind the status register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(irq_stat_r & irq_mask_r);
		end
	end

	// Read mux, evaluated during the setup cycle.
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		unique case (paddr)
			cmab_pkg::ADDR_MSKSEL:   rd_word = {16'h0000, msksel_r};
			cmab_pkg::ADDR_FULL_LO:  rd_word = {16'h0000, full_r[15:0]};
			cmab_pkg::ADDR_FULL_HI:  rd_word = {16'h0000, full_r[31:16]};
			cmab_pkg::ADDR_OVF_LO:   rd_word = {16'h0000, ovf_r[15:0]};
			cmab_pkg::ADDR_OVF_HI:   rd_word = {16'h0000, ovf_r[31:16]};
			cmab_pkg::ADDR_IRQ_STAT: rd_word = {30'h0, irq_stat_r};
			cmab_pkg::ADDR_IRQ_MASK: rd_word = {30'h0, irq_mask_r};
			default:                 rd_hit  = 1'b0;
		endcase
		for (int k = 0; k < cmab_pkg::NUM_MASK; k++) begin
			if (paddr == cmab_pkg::ADDR_MSTD0 + 8'(k * 4)) begin
				// Unimplemented bits 4 and 2 are hard zeros.
				rd_word = {16'h0000, mstd_r[k], 1'b0, id_type_match_mode_r[k], 1'b0,
					mext_r[k][17:16]};
				rd_hit  = 1'b1;
			end
			if (paddr == cmab_pkg::ADDR_MEXT0 + 8'(k * 4)) begin
				rd_word = {16'h0000, mext_r[k][15:0]};
				rd_hit  = 1'b1;
			end
		end
	end

	// APB answer: one access cycle, data and error captured at setup.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r  <= psel && !penable;
			if (psel && !penable) begin
				pslverr_r <= !rd_hit;
				prdata_r  <= (pwrite || !rd_hit) ? 32'h0000_0000 : rd_word;
			end
		end
	end

	// Feed the comparators.
	assign fi.mask_sel  = msksel_r;
	assign fi.mask_std  = mstd_r;
	assign fi.mask_ext  = mext_r;
	assign fi.mask_id_type_match_mode = id_type_match_mode_r;
	assign fi.filt_std  = filt_std_id;
	assign fi.filt_ext  = filt_ext_id;
	assign fi.filt_xen  = filter_extended_enable;
	assign fi.rx_std    = rx_std_id;
	assign fi.rx_ext    = rx_ext_id;
	assign fi.rx_is_ext = rx_is_ext;

	cmab_match u_match (
		.fi (fi.match)
	);

	// Hits are registered so the result stands one cycle after rx_valid.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hit_r       <= 8'h00;
			hit_valid_r <= 1'b0;
		end else begin
			hit_r       <= rx_valid ? fi.hit : 8'h00;
			hit_valid_r <= rx_valid;
		end
	end

	// Outputs straight from flip-flops.
	assign prdata                  = prdata_r;
	assign pready                  = pready_r;
	assign pslverr                 = pslverr_r;
	assign filter_hit              = hit_r;
	assign filter_hit_valid        = hit_valid_r;
	assign rx_buffer_full_flag     = full_r;
	assign rx_buffer_overflow_flag = ovf_r;
	assign irq                     = irq_r;

	// Checks on the block's own behaviour.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic f0_std_exact;
	assign f0_std_exact = ((rx_std_id ^ filt_std_id[0]) & mstd_r[0]) == '0;

	// Filter 15 against the mask that its own field selects.
	logic [1:0] f15_code;
	logic       f15_std_diff;
	assign f15_code = msksel_r[15:14];
	assign f15_std_diff = (f15_code != cmab_pkg::MSK_SRC_RSVD)
		&& (((rx_std_id ^ filt_std_id[7])
		& mstd_r[cmab_pkg::mask_index(f15_code)]) != '0);

	a_rsvd_code_nohit: assert property (
		rx_valid && msksel_r[1:0] == 2'h3 |=> !hit_r[0])
		else $error("reserved mask code gave a hit");
	a_top_field_pos: assert property (
		rx_valid && f15_std_diff |=> !hit_r[7])
		else $error("filter 15 field not at bits 15-14");
	a_std_mask_hit: assert property (
		rx_valid && msksel_r[1:0] == 2'h0 && !id_type_match_mode_r[0] && !rx_is_ext
		&& f0_std_exact |=> hit_r[0] && hit_valid_r)
		else $error("included standard bits equal but no hit");
	a_std_mask_miss: assert property (
		rx_valid && msksel_r[1:0] == 2'h0 && !f0_std_exact |=> !hit_r[0])
		else $error("included standard bit differs but hit");
	a_ext_mask_miss: assert property (
		rx_valid && msksel_r[1:0] == 2'h0 && rx_is_ext &&
		((rx_ext_id ^ filt_ext_id[0]) & mext_r[0]) != '0 |=> !hit_r[0])
		else $error("included extended bit differs but hit");
	a_type_gate: assert property (
		rx_valid && msksel_r[1:0] == 2'h1 && id_type_match_mode_r[1] &&
		rx_is_ext != filter_extended_enable[0] |=> !hit_r[0])
		else $error("frame type mismatch accepted");
	a_rsvd_read_zero: assert property (
		psel && !penable && !pwrite && paddr == cmab_pkg::ADDR_MSTD0
		|=> pready && prdata[4] == 1'b0 && prdata[2] == 1'b0)
		else $error("unimplemented mask bits read nonzero");
	a_full_set: assert property (
		buf_wr |=> full_r[$past(buf_idx)])
		else $error("buffer write did not set full flag");
	a_full_no_sw_set: assert property (
		!buf_wr |=> (full_r & ~$past(full_r)) == '0)
		else $error("full flag rose without a buffer write");
	a_ovf_set: assert property (
		buf_wr && full_r[buf_idx] |=> ovf_r[$past(buf_idx)])
		else $error("write to full buffer missed overflow");
	a_ovf_hold: assert property (
		1'b1 |=> ($past(ovf_r) & ~ovf_r & ~$past(ovf_clr)) == '0)
		else $error("overflow flag fell without a clear");
	a_irq_follow: assert property (
		irq_ev != 2'h0 && irq_mask_r == 2'h3 |-> ##2 irq)
		else $error("unmasked event did not raise interrupt");

	// Answer timing on the register bus and the match result.
	a_apb_answer: assert property (
		psel && !penable |=> pready)
		else $error("no ready after a setup cycle");
	a_ready_pulse: assert property (
		pready |=> !pready)
		else $error("ready stood longer than one cycle");
	a_err_unmapped: assert property (
		psel && !penable && !rd_hit |=> pslverr && prdata == 32'h0)
		else $error("unmapped access gave no error or nonzero data");
	a_hit_pulse: assert property (
		rx_valid |=> hit_valid_r)
		else $error("identifier gave no match result");
	a_hit_idle: assert property (
		!rx_valid |=> !hit_valid_r && hit_r == 8'h00)
		else $error("match result without an identifier");

	// Flag, select and interrupt state.
	a_full_clear: assert property (
		1'b1 |=> (full_r & $past(full_clr) & ~$past(full_set)) == '0)
		else $error("full flag survived a clear");
	a_ovf_cause: assert property (
		1'b1 |=> (ovf_r & ~$past(ovf_r) & ~$past(full_r)) == '0)
		else $error("overflow set for a buffer that was not full");
	a_sel_hold: assert property (
		!(wr_en && paddr == cmab_pkg::ADDR_MSKSEL)
		|=> $stable(msksel_r))
		else $error("mask select changed without a write");
	a_irq_masked: assert property (
		irq_mask_r == 2'h0 |=> !irq)
		else $error("masked interrupt reached the pin");

	c_overflow: cover property (buf_wr && full_r[buf_idx]);
	c_mask2_hit: cover property (rx_valid && msksel_r[1:0] == 2'h2
		##1 hit_r[0]);
	c_irq_rise: cover property ($rose(irq));
	c_set_and_clear: cover property (buf_wr && full_clr != '0);
	c_ovf_hi: cover property (ovf_set[31:16] != 16'h0000);

endmodule

// File: bench/cmab_rx_engine.sv
// Behavioural model of the receive protocol engine feeding the block.
`timescale 1ns/1ps
module cmab_rx_engine (
	// Clock.
	input  wire logic        pclk,
	// Received identifier.
	output logic             rx_valid,
	output logic [10:0]      rx_std_id,
	output logic [17:0]      rx_ext_id,
	output logic             rx_is_ext,
	// Buffer write notice.
	output logic             buf_wr,
	output logic [4:0]       buf_idx
);
	// Idle state at time zero.
	initial begin
		rx_valid  = 1'b0;
		rx_std_id = 11'h000;
		rx_ext_id = 18'h00000;
		rx_is_ext = 1'b0;
		buf_wr    = 1'b0;
		buf_idx   = 5'h00;
	end

	// One-cycle identifier pulse. Outside it the fields are inverted so
	// that nothing downstream can lean on stale identifier values.
	task automatic send_id(input logic [10:0] s, input logic [17:0] e,
		input logic x);
		@(posedge pclk);
		rx_valid  <= 1'b1;
		rx_std_id <= s;
		rx_ext_id <= e;
		rx_is_ext <= x;
		@(posedge pclk);
		rx_valid  <= 1'b0;
		rx_std_id <= ~s;
		rx_ext_id <= ~e;
		rx_is_ext <= ~x;
	endtask

	// One-cycle notice that a message went into buffer n.
	task automatic write_buf(input logic [4:0] n);
		@(posedge pclk);
		buf_wr  <= 1'b1;
		buf_idx <= n;
		@(posedge pclk);
		buf_wr  <= 1'b0;
		buf_idx <= ~n;
	endtask
endmodule

// File: bench/cmab_tb_top.sv
// Self-checking testbench for the receive mask and buffer status block.
`timescale 1ns/1ps
module cmab_tb_top;
	logic                pclk;
	logic                presetn;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [7:0]          paddr;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic [7:0][10:0]    fstd;
	logic [7:0][17:0]    fext;
	logic [7:0]          fxen;
	logic                rx_valid;
	logic [10:0]         rx_std_id;
	logic [17:0]         rx_ext_id;
	logic                rx_is_ext;
	logic                buf_wr;
	logic [4:0]          buf_idx;
	logic [7:0]          filter_hit;
	logic                filter_hit_valid;
	logic [31:0]         full_flag;
	logic [31:0]         ovf_flag;
	logic                irq;
	int                  n_errors;
	int                  n_checks;
	logic [31:0]         rng;
	logic [33:0]         q_apb [$];
	logic [7:0]          q_hit [$];
	logic [15:0]         sel_s;
	logic [10:0]         m_std [3];
	logic [17:0]         m_ext [3];
	logic                m_id_type_match_mode [3];
	logic [7:0]          rst_a [6] = '{8'h00, 8'h1C, 8'h20, 8'h24, 8'h28,
		8'h2C};

	cmab_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .filt_std_id(fstd), .filt_ext_id(fext),
		.filter_extended_enable(fxen), .rx_valid(rx_valid),
		.rx_std_id(rx_std_id), .rx_ext_id(rx_ext_id),
		.rx_is_ext(rx_is_ext), .buf_wr(buf_wr), .buf_idx(buf_idx),
		.filter_hit(filter_hit), .filter_hit_valid(filter_hit_valid),
		.rx_buffer_full_flag(full_flag),
		.rx_buffer_overflow_flag(ovf_flag), .irq(irq));

	cmab_rx_engine eng_u (.pclk(pclk), .rx_valid(rx_valid),
		.rx_std_id(rx_std_id), .rx_ext_id(rx_ext_id),
		.rx_is_ext(rx_is_ext), .buf_wr(buf_wr), .buf_idx(buf_idx));

	// Free-running 125 MHz clock.
	always #4 pclk = ~pclk;

	// Xorshift source; a fixed start keeps every run the same.
	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	// Common comparison with counting and a one-line report.
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_apb(input logic [31:0] g, input logic [31:0] e);
		cmp(g, e);
	endtask
	task automatic chk_hit(input logic [7:0] g, input logic [7:0] e);
		cmp({24'h0, g}, {24'h0, e});
	endtask
	task automatic chk_sig(input logic [31:0] g, input logic [31:0] e);
		cmp(g, e);
	endtask

	// Closing report, reached from the main flow and the watchdog.
	task automatic test_done;
		$display("checks=%0d errors=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// APB transfer; the expected answer is queued for the monitor.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] ex, input logic er);
		int k;
		q_apb.push_back({w, er, ex});
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (k == 20) begin
			n_errors++;
			test_done();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Programs mask m: standard word, then the extended word.
	task automatic set_mask(input int m, input logic [10:0] s,
		input logic [17:0] e, input logic md);
		m_std[m]  = s;
		m_ext[m]  = e;
		m_id_type_match_mode[m] = md;
		apb(1'b1, 8'(8'h04 + 4 * m), {16'h0, s, 1'b0, md, 1'b0, e[17:16]},
			0, 1'b0);
		apb(1'b1, 8'(8'h10 + 4 * m), {16'h0, e[15:0]}, 0, 1'b0);
	endtask

	// Reference acceptance decision built from the shadow settings.
	function automatic logic [7:0] exp_hit(input logic [10:0] s,
		input logic [17:0] e, input logic x);
		logic [1:0] c;
		logic       ok;
		for (int i = 0; i < 8; i++) begin
			c  = sel_s[2*i+:2];
			ok = ((s ^ fstd[i]) & m_std[c]) == 11'h000;
			if (x)
				ok &= ((e ^ fext[i]) & m_ext[c]) == 18'h0;
			if (m_id_type_match_mode[c] && (x != fxen[i]))
				ok = 1'b0;
			exp_hit[i] = ok;
		end
	endfunction

	// Monitor of completed APB transfers.
	always @(posedge pclk) begin
		logic [33:0] e;
		if (psel && penable && pready === 1'b1) begin
			if (q_apb.size() == 0) begin
				e = {1'b1, 1'b0, 32'h0};
			end else begin
				e = q_apb.pop_front();
			end
			if (!e[33])
				chk_apb(prdata, e[31:0]);
			chk_apb({31'h0, pslverr}, {31'h0, e[32]});
		end
	end

	// Monitor of filter hit results.
	always @(posedge pclk) begin
		if (filter_hit_valid === 1'b1) begin
			if (q_hit.size() == 0)
				chk_hit(filter_hit, 8'hFF);
			else
				chk_hit(filter_hit, q_hit.pop_front());
		end
	end

	// Watchdog against a hang anywhere in the run.
	initial begin
		#500000;
		n_errors++;
		test_done();
	end

	// Main sequence.
	initial begin
		logic [10:0] s;
		logic [17:0] e;
		logic        x;
		int          k;
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
		paddr = 0; pwdata = 0; fstd = 0; fext = 0; fxen = 0;
		n_errors = 0; n_checks = 0; rng = 32'hF014;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rst_a[i])
			apb(1'b0, rst_a[i], 0, 32'h0, 1'b0);
		apb(1'b1, 8'h04, 32'h0000_FFFF, 0, 1'b0);
		apb(1'b0, 8'h04, 0, 32'h0000_FFEB, 1'b0);
		apb(1'b0, 8'h40, 0, 32'h0, 1'b1);
		apb(1'b1, 8'h40, 32'hFFFF, 0, 1'b1);
		// Random matching rounds; each field avoids the reserved code.
		for (int r = 0; r < 60; r++) begin
			if (r % 15 == 0) begin
				for (int i = 0; i < 8; i++)
					sel_s[2*i+:2] = 2'(rnd() % 3);
				apb(1'b1, 8'h00, {16'h0, sel_s}, 0, 1'b0);
				apb(1'b0, 8'h00, 0, {16'h0, sel_s}, 1'b0);
				for (int m = 0; m < 3; m++)
					set_mask(m, 11'(rnd() & rnd()), 18'(rnd() & rnd()),
						rnd() % 2 == 0);
			end
			@(posedge pclk);
			for (int i = 0; i < 8; i++) begin
				fstd[i] <= 11'(rnd());
				fext[i] <= 18'(rnd());
				fxen[i] <= rnd() % 2 == 0;
			end
			@(posedge pclk);
			k = int'(rnd() % 8);
			s = rnd() % 2 ? fstd[k] : 11'(rnd());
			e = rnd() % 2 ? fext[k] : 18'(rnd());
			x = rnd() % 2 ? fxen[k] : 1'(rnd());
			q_hit.push_back(exp_hit(s, e, x));
			eng_u.send_id(s, e, x);
		end
		for (k = 0; k < 20 && q_hit.size() > 0; k++)
			@(posedge pclk);
		chk_sig(q_hit.size(), 0);
		// Buffer flags, overflow and interrupt.
		eng_u.write_buf(5'd3);
		eng_u.write_buf(5'd3);
		eng_u.write_buf(5'd20);
		repeat (2) @(posedge pclk);
		chk_sig(full_flag, 32'h0010_0008);
		chk_sig(ovf_flag, 32'h0000_0008);
		apb(1'b0, 8'h1C, 0, 32'h0008, 1'b0);
		apb(1'b0, 8'h20, 0, 32'h0010, 1'b0);
		apb(1'b0, 8'h24, 0, 32'h0008, 1'b0);
		apb(1'b0, 8'h2C, 0, 32'h0003, 1'b0);
		chk_sig(irq, 1'b0);
		apb(1'b1, 8'h30, 32'h3, 0, 1'b0);
		repeat (3) @(posedge pclk);
		chk_sig(irq, 1'b1);
		apb(1'b1, 8'h2C, 32'h3, 0, 1'b0);
		repeat (3) @(posedge pclk);
		chk_sig(irq, 1'b0);
		apb(1'b1, 8'h28, 32'hFFFF, 0, 1'b0);
		apb(1'b0, 8'h28, 0, 32'h0, 1'b0);
		apb(1'b1, 8'h1C, 32'hFFF7, 0, 1'b0);
		apb(1'b0, 8'h1C, 0, 32'h0008, 1'b0);
		apb(1'b1, 8'h1C, 32'h0008, 0, 1'b0);
		apb(1'b0, 8'h1C, 0, 32'h0, 1'b0);
		apb(1'b0, 8'h24, 0, 32'h0008, 1'b0);
		apb(1'b1, 8'h24, 32'h0008, 0, 1'b0);
		apb(1'b0, 8'h24, 0, 32'h0, 1'b0);
		repeat (2) @(posedge pclk);
		chk_sig(full_flag, 32'h0010_0000);
		// Overflow in the high half, then a write and a clear in one cycle.
		eng_u.write_buf(5'd20);
		fork
			apb(1'b1, 8'h1C, 32'h0020, 0, 1'b0);
			begin
				@(posedge pclk);
				eng_u.write_buf(5'd5);
			end
		join
		repeat (3) @(posedge pclk);
		chk_sig(irq, 1'b1);
		apb(1'b0, 8'h1C, 0, 32'h0020, 1'b0);
		apb(1'b0, 8'h28, 0, 32'h0010, 1'b0);
		// Reset in mid-run returns selects and flags to zero.
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk_sig(full_flag, 32'h0);
		chk_sig(ovf_flag, 32'h0);
		chk_sig(irq, 1'b0);
		presetn <= 1'b1;
		foreach (rst_a[i])
			apb(1'b0, rst_a[i], 0, 32'h0, 1'b0);
		test_done();
	end
endmodule
